// ===== core/edge_capture.sv
`timescale 1ns/1ps

// Detects the selected edge on one capture input and latches the count.
module edge_capture
   import frt_cc_pkg::*;
#(
   parameter int WIDTH = 16
) (
   input wire logic i_core_clk,
   input wire logic i_srst,
   input wire logic i_pin,
   input wire logic i_rising,
   input wire logic [WIDTH-1:0] i_count,
   output logic o_event,
   output logic [WIDTH-1:0] o_value
);
   logic prev_reg;

   if (WIDTH < 2) begin : g_width_check
      $error("WIDTH must be at least 2");
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         prev_reg <= 1'b0;
      end else begin
         prev_reg <= i_pin;
      end
   end

   // Rising when the select bit is 1, falling when it is 0.
   assign o_event = i_rising ? (i_pin & ~prev_reg) : (~i_pin & prev_reg);

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         o_value <= '0;
      end else if (o_event) begin
         o_value <= i_count;
      end
   end
endmodule // edge_capture

// ===== core/frt_capture_compare.sv
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`include "frt_cc_cfg.svh"

// Functional notes
// - capture A request gated by its enable
// - status flags cleared by writing zero to the status register or one to the clear register
// - compare B match sets its flag
// - edge-select A picks falling or rising
// - valid A edge latches counter
// - D captures edge or old B value
module frt_capture_compare
   import frt_cc_pkg::*;
#(
   parameter int WIDTH = 16
) (
   input wire logic i_core_clk,
   input wire logic i_srst,
   input wire logic i_capture_input_a,
   input wire logic i_capture_input_b,
   input wire logic i_capture_input_d,
   input wire logic [7:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [7:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   output logic o_irq
);
   if (WIDTH != 16) begin : g_width_check
      $error("WIDTH must be 16 to fit the register words");
   end

   logic [WIDTH-1:0] free_running_counter;
   logic [WIDTH-1:0] compare_b_value;
   logic [7:0] timer_irq_enable_reg;
   logic [7:0] timer_ctrl_status_reg;
   logic [7:0] control_reg;
   logic [WIDTH-1:0] cap_a_value;
   logic [WIDTH-1:0] capture_b_value;
   logic [WIDTH-1:0] cap_d_value;
   logic ev_a;
   logic ev_b;
   logic ev_d;
   logic compare_b_match_flag;
   logic [7:0] status_set;
   logic [7:0] status_clr;

   // ***************************************************************
   // Write channel.
   // ***************************************************************
   logic aw_held_reg;
   logic w_held_reg;
   logic [7:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0] wstrb_reg;
   logic do_write;
   logic [7:0] wa;
   logic [31:0] wd;
   logic wr_low;

   assign do_write = aw_held_reg & w_held_reg & ~o_bvalid;
   assign wa = awaddr_reg;
   assign wd = wdata_reg;
   assign wr_low = wstrb_reg[0];

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awaddr_reg <= 8'h00;
         wdata_reg <= 32'h00000000;
         wstrb_reg <= 4'h0;
         o_awready <= 1'b0;
         o_wready <= 1'b0;
         o_bvalid <= 1'b0;
         o_bresp <= RESP_OKAY;
      end else begin
         o_awready <= ~aw_held_reg & ~o_awready & ~o_bvalid;
         o_wready <= ~w_held_reg & ~o_wready & ~o_bvalid;
         if (i_awvalid & o_awready) begin
            aw_held_reg <= 1'b1;
            awaddr_reg <= i_awaddr;
            o_awready <= 1'b0;
         end
         if (i_wvalid & o_wready) begin
            w_held_reg <= 1'b1;
            wdata_reg <= i_wdata;
            wstrb_reg <= i_wstrb;
            o_wready <= 1'b0;
         end
         if (do_write) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            o_bvalid <= 1'b1;
            if (wa == `OFS_IRQ_ENABLE || wa == `OFS_CTRL_STATUS ||
                wa == `OFS_IRQ_CLEAR || wa == `OFS_COMPARE_B ||
                wa == `OFS_CONTROL || wa == `OFS_COUNTER) begin
               o_bresp <= RESP_OKAY;
            end else begin
               o_bresp <= RESP_SLVERR;
            end
         end else if (o_bvalid & i_bready) begin
            o_bvalid <= 1'b0;
         end
      end
   end

   // ***************************************************************
   // Software registers.
   // ***************************************************************
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         timer_irq_enable_reg <= `RST_IRQ_ENABLE;
         control_reg <= `RST_CONTROL;
         compare_b_value <= `RST_COMPARE_B;
      end else if (do_write) begin
         if (wa == `OFS_IRQ_ENABLE && wr_low) begin
            timer_irq_enable_reg <= wd[7:0] & `STATUS_MASK;
         end else if (wa == `OFS_CONTROL && wr_low) begin
            control_reg <= wd[7:0];
         end else if (wa == `OFS_COMPARE_B) begin
            if (wstrb_reg[0]) begin
               compare_b_value[7:0] <= wd[7:0];
            end
            if (wstrb_reg[1]) begin
               compare_b_value[15:8] <= wd[15:8];
            end
         end
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         free_running_counter <= `RST_COUNTER;
      end else if (do_write && wa == `OFS_COUNTER && wr_low) begin
         free_running_counter <= wd[15:0];
      end else begin
         free_running_counter <= free_running_counter + 16'h0001;
      end
   end

   // ***************************************************************
   // Capture paths.
   // ***************************************************************
   edge_capture #(.WIDTH(WIDTH)) u_cap_a (
      .i_core_clk(i_core_clk),
      .i_srst(i_srst),
      .i_pin(i_capture_input_a),
      .i_rising(control_reg[`BIT_EDGE_A]),
      .i_count(free_running_counter),
      .o_event(ev_a),
      .o_value(cap_a_value)
   );

   edge_capture #(.WIDTH(WIDTH)) u_cap_b (
      .i_core_clk(i_core_clk),
      .i_srst(i_srst),
      .i_pin(i_capture_input_b),
      .i_rising(control_reg[`BIT_EDGE_B]),
      .i_count(free_running_counter),
      .o_event(ev_b),
      .o_value(capture_b_value)
   );

   edge_capture #(.WIDTH(WIDTH)) u_cap_d (
      .i_core_clk(i_core_clk),
      .i_srst(i_srst),
      .i_pin(i_capture_input_d),
      .i_rising(control_reg[`BIT_EDGE_D]),
      .i_count(free_running_counter),
      .o_event(ev_d),
      .o_value()
   );

   // In buffer mode the old B value moves into D as B is overwritten.
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         cap_d_value <= '0;
      end else if (control_reg[`BIT_BUFFER_D]) begin
         if (ev_b) begin
            cap_d_value <= capture_b_value;
         end
      end else if (ev_d) begin
         cap_d_value <= free_running_counter;
      end
   end

   // ***************************************************************
   // Status flags and interrupt.
   // ***************************************************************
   assign compare_b_match_flag = (free_running_counter == compare_b_value);

   always_comb begin
      status_set = 8'h00;
      status_set[`BIT_CAP_A] = ev_a;
      status_set[`BIT_CAP_B] = ev_b;
      status_set[`BIT_CAP_D] = ev_d & ~control_reg[`BIT_BUFFER_D];
      status_set[`BIT_CMP_B] = compare_b_match_flag;
      status_clr = 8'h00;
      if (do_write && wr_low) begin
         if (wa == `OFS_CTRL_STATUS) begin
            status_clr = ~wd[7:0] & `STATUS_MASK;
         end else if (wa == `OFS_IRQ_CLEAR) begin
            status_clr = wd[7:0] & `STATUS_MASK;
         end
      end
   end

   // A set in the same cycle as a clear wins.
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         timer_ctrl_status_reg <= 8'h00;
      end else begin
         timer_ctrl_status_reg <=
            (timer_ctrl_status_reg & ~status_clr) | status_set;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(timer_ctrl_status_reg & timer_irq_enable_reg);
      end
   end

   // ***************************************************************
   // Read channel.
   // ***************************************************************
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         o_arready <= 1'b0;
         o_rvalid <= 1'b0;
         o_rdata <= 32'h00000000;
         o_rresp <= RESP_OKAY;
      end else if (o_rvalid) begin
         if (i_rready) begin
            o_rvalid <= 1'b0;
         end
      end else if (i_arvalid & o_arready) begin
         o_arready <= 1'b0;
         o_rvalid <= 1'b1;
         o_rresp <= RESP_OKAY;
         if (i_araddr == `OFS_IRQ_ENABLE) begin
            o_rdata <= {24'h000000, timer_irq_enable_reg};
         end else if (i_araddr == `OFS_CTRL_STATUS) begin
            o_rdata <= {24'h000000, timer_ctrl_status_reg};
         end else if (i_araddr == `OFS_IRQ_CLEAR) begin
            o_rdata <= 32'h00000000;
         end else if (i_araddr == `OFS_COUNTER) begin
            o_rdata <= {16'h0000, free_running_counter};
         end else if (i_araddr == `OFS_COMPARE_B) begin
            o_rdata <= {16'h0000, compare_b_value};
         end else if (i_araddr == `OFS_CAPTURE_A) begin
            o_rdata <= {16'h0000, cap_a_value};
         end else if (i_araddr == `OFS_CAPTURE_B) begin
            o_rdata <= {16'h0000, capture_b_value};
         end else if (i_araddr == `OFS_CAPTURE_D) begin
            o_rdata <= {16'h0000, cap_d_value};
         end else if (i_araddr == `OFS_CONTROL) begin
            o_rdata <= {24'h000000, control_reg};
         end else begin
            o_rdata <= 32'h00000000;
            o_rresp <= RESP_SLVERR;
         end
      end else begin
         o_arready <= 1'b1;
      end
   end
endmodule // frt_capture_compare

// ===== inc/frt_cc_cfg.svh
`ifndef FRT_CC_CFG_SVH
`define FRT_CC_CFG_SVH

// ***************************************************************
// Register byte offsets.
// ***************************************************************
`define OFS_IRQ_ENABLE 8'h00
`define OFS_CTRL_STATUS 8'h04
`define OFS_IRQ_CLEAR 8'h08
`define OFS_COUNTER 8'h0C
`define OFS_COMPARE_B 8'h10
`define OFS_CAPTURE_A 8'h14
`define OFS_CAPTURE_B 8'h18
`define OFS_CAPTURE_D 8'h1C
`define OFS_CONTROL 8'h20

// ***************************************************************
// Field positions in the status, enable and clear layout.
// ***************************************************************
`define BIT_CAP_A 7
`define BIT_CAP_B 6
`define BIT_CAP_D 4
`define BIT_CMP_B 2
`define STATUS_MASK 8'hD4

// ***************************************************************
// Field positions in the control register.
// ***************************************************************
`define BIT_EDGE_A 0
`define BIT_EDGE_B 1
`define BIT_EDGE_D 3
`define BIT_BUFFER_D 4

// ***************************************************************
// Reset values.
// ***************************************************************
`define RST_IRQ_ENABLE 8'h00
`define RST_CONTROL 8'h00
`define RST_COMPARE_B 16'hFFFF
`define RST_COUNTER 16'h0000

`endif

// ===== inc/frt_cc_pkg.sv
package frt_cc_pkg;
   typedef logic [15:0] count_t;
   typedef enum logic [1:0] {
      RESP_OKAY = 2'h0,
      RESP_SLVERR = 2'h2
   } axi_resp_e;
endpackage

// ===== verification/capture_pins.sv
`timescale 1ns/1ps
// Drives the three capture pins, changing just after a clock edge.
module capture_pins (
   input wire logic i_core_clk,
   input wire logic [2:0] i_level,
   output logic [2:0] o_pins
);
   initial o_pins = 3'h0;
   always @(posedge i_core_clk) begin
      o_pins <= i_level;
   end
endmodule // capture_pins

// ===== verification/frt_capture_compare_bench.sv
`timescale 1ns/1ps
`include "frt_cc_cfg.svh"
module frt_capture_compare_bench;
   import frt_cc_pkg::*;
   logic core_clk = 1'b0, srst = 1'b1;
   logic [7:0] awaddr = 8'h0, araddr = 8'h0;
   logic [31:0] wdata = 32'h0, rdata, rd, v0, v1;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp;
   logic [2:0] lv = 3'h0, pins;
   int failures = 0, checked = 0;
   always #25 core_clk = ~core_clk;
   capture_pins capture_pins_i (.i_core_clk(core_clk), .i_level(lv),
      .o_pins(pins));
   frt_capture_compare frt_capture_compare_i (.i_core_clk(core_clk),
      .i_srst(srst), .i_capture_input_a(pins[0]),
      .i_capture_input_b(pins[1]), .i_capture_input_d(pins[2]),
      .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
      .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid),
      .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
      .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
      .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
      .o_rvalid(rvalid), .i_rready(rready), .o_irq(irq));
   // ****
   // Bus and compare helpers.
   // ****
   task results;
      $display("failures %0d checked %0d", failures, checked);
      if (failures == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task chk(input string s, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         $display("mismatch %s expected %h seen %h", s, e, g);
         failures++;
      end
   endtask
   task tmo(input int n);
      if (n >= 50) begin
         $display("mismatch handshake expected answer seen timeout");
         failures++;
         results;
      end
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
      int n;
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid && n < 50);
      bready <= 1'b0;
      tmo(n);
      chk("bresp", e, bresp);
   endtask
   task rdr(input logic [7:0] a, input logic [1:0] e);
      int n;
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
         if (arready) arvalid <= 1'b0;
         rd = rdata;
      end while (!rvalid && n < 50);
      rready <= 1'b0;
      tmo(n);
      chk("rresp", e, rresp);
   endtask
   task pin(input logic [2:0] l);
      @(posedge core_clk);
      lv <= l;
      repeat (4) @(posedge core_clk);
   endtask
   // Reads the counter around a pin change and checks the capture.
   task cap(input logic [2:0] l, input logic [7:0] a);
      rdr(`OFS_COUNTER, RESP_OKAY);
      v0 = rd;
      pin(l);
      rdr(`OFS_COUNTER, RESP_OKAY);
      v1 = rd;
      rdr(a, RESP_OKAY);
      chk("capture in window", 32'h1, rd > v0 && rd < v1);
   endtask
   task sc_regs;
      rdr(`OFS_IRQ_ENABLE, RESP_OKAY);
      chk("enable reset", 32'h0, rd);
      rdr(`OFS_COMPARE_B, RESP_OKAY);
      chk("compare_b reset", 32'hFFFF, rd);
      rdr(8'h40, RESP_SLVERR);
      wr(8'h44, 32'hFF, RESP_SLVERR);
   endtask
   task sc_cap_a;
      wr(`OFS_CONTROL, 32'h0, RESP_OKAY);
      wr(`OFS_CTRL_STATUS, 32'h0, RESP_OKAY);
      pin(3'b001);
      rdr(`OFS_CTRL_STATUS, RESP_OKAY);
      chk("rise ignored", 32'h0, rd & 32'h80);
      cap(3'b000, `OFS_CAPTURE_A);
      rdr(`OFS_CTRL_STATUS, RESP_OKAY);
      chk("fall flag", 32'h80, rd & 32'h80);
      chk("irq masked", 32'h0, irq);
      wr(`OFS_IRQ_ENABLE, 32'h80, RESP_OKAY);
      pin(3'b000);
      chk("irq enabled", 32'h1, irq);
      wr(`OFS_CTRL_STATUS, 32'hFF, RESP_OKAY);
      pin(3'b000);
      chk("irq after one", 32'h1, irq);
      wr(`OFS_CTRL_STATUS, 32'h7F, RESP_OKAY);
      pin(3'b000);
      chk("irq after zero", 32'h0, irq);
      wr(`OFS_CONTROL, 32'h1, RESP_OKAY);
      cap(3'b001, `OFS_CAPTURE_A);
      chk("rise irq", 32'h1, irq);
   endtask
   task sc_compare;
      wr(`OFS_COMPARE_B, 32'h100, RESP_OKAY);
      wr(`OFS_COUNTER, 32'h0, RESP_OKAY);
      wr(`OFS_CTRL_STATUS, 32'h0, RESP_OKAY);
      rdr(`OFS_CTRL_STATUS, RESP_OKAY);
      chk("no match yet", 32'h0, rd & 32'h04);
      repeat (300) @(posedge core_clk);
      rdr(`OFS_CTRL_STATUS, RESP_OKAY);
      chk("match flag", 32'h04, rd & 32'h04);
      wr(`OFS_IRQ_CLEAR, 32'h04, RESP_OKAY);
      rdr(`OFS_CTRL_STATUS, RESP_OKAY);
      chk("clear register", 32'h0, rd & 32'h04);
   endtask
   task sc_buffer;
      wr(`OFS_CONTROL, 32'h08, RESP_OKAY);
      cap(3'b100, `OFS_CAPTURE_D);
      pin(3'b000);
      wr(`OFS_CONTROL, 32'h12, RESP_OKAY);
      pin(3'b010);
      rdr(`OFS_CAPTURE_B, RESP_OKAY);
      v0 = rd;
      pin(3'b000);
      pin(3'b110);
      rdr(`OFS_CAPTURE_D, RESP_OKAY);
      chk("buffered d", v0, rd);
   endtask
   initial begin
      repeat (16) @(posedge core_clk);
      srst <= 1'b0;
      sc_regs;
      sc_cap_a;
      sc_compare;
      sc_buffer;
      results;
   end
endmodule // frt_capture_compare_bench
bind frt_capture_compare frt_cc_props frt_cc_props_i (.i_core_clk,
   .i_srst, .i_capture_input_a, .i_awaddr, .i_awvalid, .i_wdata, .i_wstrb,
   .i_wvalid, .o_awready, .o_wready, .o_bresp, .o_bvalid, .i_bready,
   .o_arready, .o_rdata, .o_rresp, .o_rvalid, .i_rready, .o_irq);

// ===== verification/frt_cc_props.sv
`timescale 1ns/1ps
`include "frt_cc_cfg.svh"
// Handshake, reset and capture A interrupt checks seen at the top-level ports.
module frt_cc_props
   import frt_cc_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_srst,
   input wire logic i_capture_input_a,
   input wire logic [7:0] i_awaddr,
   input wire logic i_awvalid,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   input wire logic o_awready,
   input wire logic o_wready,
   input wire logic [1:0] o_bresp,
   input wire logic o_bvalid,
   input wire logic i_bready,
   input wire logic o_arready,
   input wire logic [31:0] o_rdata,
   input wire logic [1:0] o_rresp,
   input wire logic o_rvalid,
   input wire logic i_rready,
   input wire logic o_irq
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_srst);
   logic aw_seen_reg;
   logic w_seen_reg;
   logic [7:0] addr_seen_reg;
   logic [7:0] data_seen_reg;
   logic lane0_seen_reg;
   logic edge_a_sel_reg;
   logic enable_a_reg;
   logic landed;
   // A write lands once address and data are both held and no response
   // is pending; the edge select and enable for capture A follow it.
   assign landed = aw_seen_reg && w_seen_reg && !o_bvalid;
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         aw_seen_reg <= 1'b0;
         w_seen_reg <= 1'b0;
         addr_seen_reg <= 8'h00;
         data_seen_reg <= 8'h00;
         lane0_seen_reg <= 1'b0;
         edge_a_sel_reg <= 1'b0;
         enable_a_reg <= 1'b0;
      end else begin
         if (i_awvalid && o_awready) begin
            aw_seen_reg <= 1'b1;
            addr_seen_reg <= i_awaddr;
         end
         if (i_wvalid && o_wready) begin
            w_seen_reg <= 1'b1;
            data_seen_reg <= i_wdata[7:0];
            lane0_seen_reg <= i_wstrb[0];
         end
         if (landed) begin
            aw_seen_reg <= 1'b0;
            w_seen_reg <= 1'b0;
            if (lane0_seen_reg && addr_seen_reg == `OFS_CONTROL) begin
               edge_a_sel_reg <= data_seen_reg[`BIT_EDGE_A];
            end
            if (lane0_seen_reg && addr_seen_reg == `OFS_IRQ_ENABLE) begin
               enable_a_reg <= data_seen_reg[`BIT_CAP_A];
            end
         end
      end
   end
   AST_CAP_A_IRQ: assert property (!$past(i_srst) && enable_a_reg &&
      (edge_a_sel_reg ? $rose(i_capture_input_a) :
      $fell(i_capture_input_a)) ##1 enable_a_reg |=> o_irq)
      else $error("capture A event raised no request");
   AST_RST_QUIET: assert property (@(posedge i_core_clk) disable iff (1'b0)
      i_srst |=> !o_bvalid && !o_rvalid && !o_irq)
      else $error("outputs not idle after reset");
   AST_BV_HOLD: assert property (o_bvalid && !i_bready |=>
      o_bvalid && $stable(o_bresp)) else $error("write response dropped");
   AST_BV_DROP: assert property (o_bvalid && i_bready |=> !o_bvalid)
      else $error("write response repeated");
   AST_RV_HOLD: assert property (o_rvalid && !i_rready |=>
      o_rvalid && $stable(o_rdata)) else $error("read data dropped");
   AST_RV_DROP: assert property (o_rvalid && i_rready |=> !o_rvalid)
      else $error("read data repeated");
   AST_W_BUSY: assert property (o_bvalid |-> !o_awready && !o_wready)
      else $error("write taken during response");
   AST_R_BUSY: assert property (o_rvalid |-> !o_arready)
      else $error("read taken during response");
   AST_ERR_ZERO: assert property (o_rvalid && o_rresp == RESP_SLVERR
      |-> o_rdata == 32'h0) else $error("refused read returned data");
   AST_BRESP: assert property (o_bvalid |->
      o_bresp == RESP_OKAY || o_bresp == RESP_SLVERR)
      else $error("bad write response code");
   cover property ($rose(o_irq));
   cover property (o_bvalid && o_bresp == RESP_SLVERR);
   cover property (o_rvalid && i_rready);
endmodule // frt_cc_props
